// [mab_pkg.sv]
/*
 * mab_pkg: shared constants and types for the accumulator, bit and skip
 * execute block.
 * Assumes: users refer to every item as mab_pkg::name; no import.
 */
package mab_pkg;

   localparam int unsigned DATA_W = 8;
   localparam int unsigned FADDR_W = 7;
   localparam int unsigned BIT_W = 3;
   localparam int unsigned BUS_AW = 4;

   // file address span and the one address that maps onto the pins
   localparam logic [6:0] FADDR_MAX = 7'h7F;
   localparam logic [6:0] PORT_FADDR = 7'h06;

   // destination select encoding
   localparam logic DEST_ACC = 1'h0;
   localparam logic DEST_FILE = 1'h1;

   // software register offsets (word index on the plain port)
   localparam logic [3:0] OFS_ACC = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h1;
   localparam logic [3:0] OFS_EXEC = 4'h2;

   // status field positions
   localparam int unsigned ST_C = 0;
   localparam int unsigned ST_NHF = 1;
   localparam int unsigned ST_Z = 2;

   // values after reset
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [2:0] STATUS_RST = 3'h0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // cycles taken by a skip that is taken
   localparam int unsigned SKIP_CYCLES = 2;

   typedef enum logic [3:0] {
      MAB_NOP = 4'h0,
      MAB_ADD_IMM_TO_ACC = 4'h1,
      MAB_AND_IMM_TO_ACC = 4'h2,
      MAB_ADD_ACC_FILE = 4'h3,
      MAB_AND_ACC_FILE = 4'h4,
      MAB_ZERO_FILE_REG = 4'h5,
      MAB_BIT_CLEAR_OP = 4'h6,
      MAB_BIT_SET_OP = 4'h7,
      MAB_SKIP_IF_BIT_ONE = 4'h8,
      MAB_SKIP_IF_BIT_ZERO = 4'h9
   } mab_op_t;

   typedef struct packed {
      mab_op_t    code;
      logic [7:0] imm;
      logic [6:0] faddr;
      logic [2:0] bit_idx;
      logic       dest;
   } mab_instr_t;

   typedef struct packed {
      logic       we;
      logic [6:0] addr;
      logic [7:0] data;
   } mab_fwrite_t;

   typedef enum logic [1:0] {
      MAB_EX_RUN = 2'h0,
      MAB_EX_SKIP = 2'h1
   } mab_ex_state_t;

endpackage

// [mab_adder8.sv]
/*
 * mab_adder8: eight-bit adder with carry out of bit 7 and of bit 3.
 * Assumes: purely combinational use inside the execute block.
 */
`timescale 1ns/1ps

module mab_adder8 (
   input  wire logic [7:0] a_i,
   input  wire logic [7:0] b_i,
   output logic      [7:0] sum_o,
   output logic            carry_o,
   output logic            nibble_half_flag_o
);

   logic [4:0] low_nib;
   logic [4:0] high_nib;

   always_comb begin
      low_nib = {1'h0, a_i[3:0]} + {1'h0, b_i[3:0]};
      high_nib = {1'h0, a_i[7:4]} + {1'h0, b_i[7:4]} + {4'h0, low_nib[4]};
      sum_o = {high_nib[3:0], low_nib[3:0]};
      carry_o = high_nib[4];
      nibble_half_flag_o = low_nib[4];
   end

endmodule

// [mab_core.sv]
/*
 * mab_core: execute stage for accumulator add/and, file clear, single bit
 * set/clear and bit test with skip. One instruction per cycle.
 * Assumes: the decoder presents one instruction with instr_valid_i; the file
 * array answers file_rdata_i in the same cycle for file_raddr_o; writes are
 * taken from the registered file write group; port pins arrive asynchronously.
 */
// The implementer's own choices: strobed register access and the address map.
// Notes on behaviour
// - add immediate to accumulator, result to accumulator, update carry, half, zero.
// - AND immediate with accumulator, result to accumulator, only Z changes.
// - AND accumulator with addressed file register, only Z changes.
// - add accumulator and file register, carry, half, zero from 8-bit sum.
// - destination 0 writes accumulator, destination 1 writes the file register.
// - zero file writes 00h into the register and always sets Z.
// - bit clear forces one bit to 0, others and flags untouched.
// - bit set forces one bit to 1, others and flags untouched.
// - skip if bit one: bit set discards next instruction, two cycles.
// - skip if bit zero: bit clear discards next instruction, two cycles.
// - read-modify-write of the port register reads pin levels, not latch.
// - file address operand spans 00h to 7Fh in the current bank.
// - a true conditional test takes two cycles, second one a no-operation.
`timescale 1ns/1ps

module mab_core (
   input  wire logic               sys_clk_i,
   input  wire logic               resetn_i,
   input  wire logic               instr_valid_i,
   input  wire mab_pkg::mab_instr_t instr_i,
   output logic      [6:0]         file_raddr_o,
   input  wire logic [7:0]         file_rdata_i,
   input  wire logic [7:0]         port_pins_i,
   output mab_pkg::mab_fwrite_t    file_wr_o,
   output logic      [7:0]         acc_o,
   output logic      [2:0]         status_o,
   output logic                    nop_cycle_o,
   input  wire logic [3:0]         sw_addr_i,
   input  wire logic [7:0]         sw_wdata_i,
   input  wire logic               sw_wr_i,
   input  wire logic               sw_rd_i,
   output logic      [7:0]         sw_rdata_o
);

   ////////////////////////////////////////////////////////////////////////////
   // reset and pin synchronisers

   logic       rst_meta_q;
   logic       rst_sync_q;
   logic       rstn;
   logic [7:0] pin_meta_q;
   logic [7:0] pin_sync_q;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_meta_q <= 1'h0;
         rst_sync_q <= 1'h0;
      end else begin
         rst_meta_q <= 1'h1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rstn = rst_sync_q;

   always_ff @(posedge sys_clk_i or negedge rstn) begin
      if (!rstn) begin
         pin_meta_q <= 8'h00;
         pin_sync_q <= 8'h00;
      end else begin
         pin_meta_q <= port_pins_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand fetch

   logic [7:0] file_val;
   logic       live;
   logic [7:0] bit_mask;
   logic       tested_bit;
   logic [7:0] add_b;
   logic [7:0] sum;
   logic       sum_c;
   logic       sum_nhf;
   logic [7:0] acc_q;

   // seven address bits cover exactly 00h..7Fh; banking is outside
   assign file_raddr_o = instr_i.faddr;

   // the latch of an input pin may disagree with the pin, so use the pin
   assign file_val = (instr_i.faddr == mab_pkg::PORT_FADDR) ? pin_sync_q : file_rdata_i;

   assign bit_mask = 8'h01 << instr_i.bit_idx;
   assign tested_bit = |(file_val & bit_mask);

   assign add_b = (instr_i.code == mab_pkg::MAB_ADD_IMM_TO_ACC) ? instr_i.imm : file_val;

   mab_adder8 u_add (
      .a_i                (acc_q),
      .b_i                (add_b),
      .sum_o              (sum),
      .carry_o            (sum_c),
      .nibble_half_flag_o (sum_nhf)
   );

   ////////////////////////////////////////////////////////////////////////////
   // execute

   mab_pkg::mab_ex_state_t ex_q;
   mab_pkg::mab_ex_state_t ex_d;
   logic [7:0]             acc_d;
   logic [2:0]             status_q;
   logic [2:0]             status_d;
   mab_pkg::mab_fwrite_t   fwr_q;
   mab_pkg::mab_fwrite_t   fwr_d;
   logic [7:0]             rdata_q;
   logic [7:0]             rdata_d;
   logic [7:0]             and_b;
   logic [7:0]             and_res;
   logic                   skip_hit;

   // the instruction that arrives in the skip cycle is the discarded one
   assign live = instr_valid_i && (ex_q == mab_pkg::MAB_EX_RUN);

   assign and_b = (instr_i.code == mab_pkg::MAB_AND_IMM_TO_ACC) ? instr_i.imm : file_val;
   assign and_res = acc_q & and_b;

   always_comb begin
      skip_hit = 1'h0;
      if (live && instr_i.code == mab_pkg::MAB_SKIP_IF_BIT_ONE) begin
         skip_hit = tested_bit;
      end else if (live && instr_i.code == mab_pkg::MAB_SKIP_IF_BIT_ZERO) begin
         skip_hit = !tested_bit;
      end
   end

   // the skip cycle always ends after one cycle, valid or not
   always_comb begin
      if (ex_q == mab_pkg::MAB_EX_SKIP) begin
         ex_d = mab_pkg::MAB_EX_RUN;
      end else if (skip_hit) begin
         ex_d = mab_pkg::MAB_EX_SKIP;
      end else begin
         ex_d = mab_pkg::MAB_EX_RUN;
      end
   end

   always_comb begin
      acc_d = acc_q;
      status_d = status_q;
      fwr_d.we = 1'h0;
      fwr_d.addr = instr_i.faddr;
      fwr_d.data = file_val;
      if (live) begin
         unique case (instr_i.code)
            mab_pkg::MAB_ADD_IMM_TO_ACC: begin
               acc_d = sum;
               status_d[mab_pkg::ST_C] = sum_c;
               status_d[mab_pkg::ST_NHF] = sum_nhf;
               status_d[mab_pkg::ST_Z] = (sum == mab_pkg::ZERO_BYTE);
            end
            mab_pkg::MAB_AND_IMM_TO_ACC: begin
               acc_d = and_res;
               status_d[mab_pkg::ST_Z] = (and_res == mab_pkg::ZERO_BYTE);
            end
            mab_pkg::MAB_ADD_ACC_FILE: begin
               status_d[mab_pkg::ST_C] = sum_c;
               status_d[mab_pkg::ST_NHF] = sum_nhf;
               status_d[mab_pkg::ST_Z] = (sum == mab_pkg::ZERO_BYTE);
               if (instr_i.dest == mab_pkg::DEST_FILE) begin
                  fwr_d.we = 1'h1;
                  fwr_d.data = sum;
               end else begin
                  acc_d = sum;
               end
            end
            mab_pkg::MAB_AND_ACC_FILE: begin
               status_d[mab_pkg::ST_Z] = (and_res == mab_pkg::ZERO_BYTE);
               if (instr_i.dest == mab_pkg::DEST_FILE) begin
                  fwr_d.we = 1'h1;
                  fwr_d.data = and_res;
               end else begin
                  acc_d = and_res;
               end
            end
            mab_pkg::MAB_ZERO_FILE_REG: begin
               fwr_d.we = 1'h1;
               fwr_d.data = mab_pkg::ZERO_BYTE;
               status_d[mab_pkg::ST_Z] = 1'h1;
            end
            mab_pkg::MAB_BIT_CLEAR_OP: begin
               fwr_d.we = 1'h1;
               fwr_d.data = file_val & ~bit_mask;
            end
            mab_pkg::MAB_BIT_SET_OP: begin
               fwr_d.we = 1'h1;
               fwr_d.data = file_val | bit_mask;
            end
            mab_pkg::MAB_NOP,
            mab_pkg::MAB_SKIP_IF_BIT_ONE,
            mab_pkg::MAB_SKIP_IF_BIT_ZERO: begin
            end
            default: begin
            end
         endcase
      end
      // a software write wins over the instruction in the same cycle
      if (sw_wr_i) begin
         case (sw_addr_i)
            mab_pkg::OFS_ACC: begin
               acc_d = sw_wdata_i;
            end
            mab_pkg::OFS_STATUS: begin
               status_d = sw_wdata_i[2:0];
            end
            default: begin
            end
         endcase
      end
   end

   // read data stand only in the cycle after the strobe
   always_comb begin
      rdata_d = mab_pkg::ZERO_BYTE;
      if (sw_rd_i) begin
         case (sw_addr_i)
            mab_pkg::OFS_ACC: begin
               rdata_d = acc_q;
            end
            mab_pkg::OFS_STATUS: begin
               rdata_d = {5'h00, status_q};
            end
            mab_pkg::OFS_EXEC: begin
               rdata_d = {7'h00, (ex_q == mab_pkg::MAB_EX_SKIP)};
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn) begin
      if (!rstn) begin
         acc_q <= mab_pkg::ACC_RST;
         status_q <= mab_pkg::STATUS_RST;
         ex_q <= mab_pkg::MAB_EX_RUN;
         fwr_q <= '0;
         rdata_q <= mab_pkg::ZERO_BYTE;
      end else begin
         acc_q <= acc_d;
         status_q <= status_d;
         ex_q <= ex_d;
         fwr_q <= fwr_d;
         rdata_q <= rdata_d;
      end
   end

   // limitation: the array takes a write one cycle late, so no forwarding
   assign acc_o = acc_q;
   assign status_o = status_q;
   assign file_wr_o = fwr_q;
   assign sw_rdata_o = rdata_q;
   assign nop_cycle_o = (ex_q == mab_pkg::MAB_EX_SKIP);

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   property p_add_imm_acc;
      @(posedge sys_clk_i) disable iff (!rstn)
         live && instr_i.code == mab_pkg::MAB_ADD_IMM_TO_ACC && !sw_wr_i
         |=> acc_q == 8'($past(acc_q) + $past(instr_i.imm));
   endproperty
   a_add_imm_acc: assert property (p_add_imm_acc)
      else $error("immediate add left a wrong accumulator");

   property p_zero_flag;
      @(posedge sys_clk_i) disable iff (!rstn)
         live && !sw_wr_i && (instr_i.code == mab_pkg::MAB_ADD_IMM_TO_ACC ||
                              instr_i.code == mab_pkg::MAB_AND_IMM_TO_ACC)
         |=> status_q[mab_pkg::ST_Z] == (acc_q == mab_pkg::ZERO_BYTE);
   endproperty
   a_zero_flag: assert property (p_zero_flag)
      else $error("zero flag disagrees with the accumulator");

   property p_and_keep_carry;
      @(posedge sys_clk_i) disable iff (!rstn)
         live && instr_i.code == mab_pkg::MAB_AND_IMM_TO_ACC && !sw_wr_i
         |=> $stable(status_q[1:0]);
   endproperty
   a_and_keep_carry: assert property (p_and_keep_carry)
      else $error("immediate and changed carry or half flag");

   property p_zero_file;
      @(posedge sys_clk_i) disable iff (!rstn)
         live && instr_i.code == mab_pkg::MAB_ZERO_FILE_REG && !sw_wr_i
         |=> fwr_q.we && fwr_q.data == mab_pkg::ZERO_BYTE && status_q[mab_pkg::ST_Z];
   endproperty
   a_zero_file: assert property (p_zero_file)
      else $error("zero file did not write zero and set the zero flag");

   property p_bit_set;
      @(posedge sys_clk_i) disable iff (!rstn)
         live && instr_i.code == mab_pkg::MAB_BIT_SET_OP && !sw_wr_i
         |=> fwr_q.we && (fwr_q.data & $past(bit_mask)) == $past(bit_mask) && $stable(status_q);
   endproperty
   a_bit_set: assert property (p_bit_set)
      else $error("bit set wrong bit or touched flags");

   property p_bit_clear;
      @(posedge sys_clk_i) disable iff (!rstn)
         live && instr_i.code == mab_pkg::MAB_BIT_CLEAR_OP && !sw_wr_i
         |=> fwr_q.we && (fwr_q.data & $past(bit_mask)) == mab_pkg::ZERO_BYTE && $stable(status_q);
   endproperty
   a_bit_clear: assert property (p_bit_clear)
      else $error("bit clear wrong bit or touched flags");

   property p_skip_entry;
      @(posedge sys_clk_i) disable iff (!rstn)
         live && instr_i.code == mab_pkg::MAB_SKIP_IF_BIT_ONE && file_val[instr_i.bit_idx]
         |=> ex_q == mab_pkg::MAB_EX_SKIP;
   endproperty
   a_skip_entry: assert property (p_skip_entry)
      else $error("set bit did not start a skip cycle");

   property p_skip_discard;
      @(posedge sys_clk_i) disable iff (!rstn)
         ex_q == mab_pkg::MAB_EX_SKIP && !sw_wr_i
         |=> ex_q == mab_pkg::MAB_EX_RUN && !fwr_q.we && $stable(acc_q);
   endproperty
   a_skip_discard: assert property (p_skip_discard)
      else $error("skip cycle did not act as a no-operation");

   c_skip_taken: cover property (@(posedge sys_clk_i) disable iff (!rstn)
      ex_q == mab_pkg::MAB_EX_SKIP);
   c_port_rmw: cover property (@(posedge sys_clk_i) disable iff (!rstn)
      live && instr_i.code == mab_pkg::MAB_BIT_SET_OP && instr_i.faddr == mab_pkg::PORT_FADDR);
   c_add_carry: cover property (@(posedge sys_clk_i) disable iff (!rstn)
      live && instr_i.code == mab_pkg::MAB_ADD_IMM_TO_ACC && sum_c);
endmodule

// [mab_core_tb.sv]
/* mab_core_tb: self-checking bench for the execute block.
   Assumes: the file array is modelled here and answers in the same cycle. */
`timescale 1ns/1ps
module mab_core_tb;
   logic                 sys_clk_i = 0, resetn_i = 0, instr_valid_i = 0, sw_wr_i = 0, sw_rd_i = 0;
   logic [3:0]           sw_addr_i = 4'h0;
   logic [7:0]           sw_wdata_i = 8'h00, port_pins_i = 8'hA5, acc_o, sw_rdata_o;
   mab_pkg::mab_instr_t  instr_i = '0;
   mab_pkg::mab_fwrite_t file_wr_o;
   logic [6:0]           file_raddr_o;
   logic [2:0]           status_o;
   logic                 nop_cycle_o;
   logic [7:0]           mem [128];
   int                   failures = 0, checks = 0;
   wire logic [7:0]      file_rdata_i = mem[file_raddr_o];
   always #50 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) if (file_wr_o.we) mem[file_wr_o.addr] <= file_wr_o.data;
   mab_core mab_core_i (.sys_clk_i, .resetn_i, .instr_valid_i, .instr_i, .file_raddr_o,
      .file_rdata_i, .port_pins_i, .file_wr_o, .acc_o, .status_o, .nop_cycle_o, .sw_addr_i,
      .sw_wdata_i, .sw_wr_i, .sw_rd_i, .sw_rdata_o);
   ////////////////////////////////////////
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic ex(input mab_pkg::mab_op_t c, input logic [7:0] k, input logic [6:0] f,
                     input logic [2:0] b, input logic d);
      clk(1);
      instr_valid_i <= 1;
      instr_i <= '{c, k, f, b, d};
   endtask
   // ex leaves valid up so that two calls run back to back
   task automatic settle();
      clk(1);
      instr_valid_i <= 0;
      clk(2);
   endtask
   task automatic sw_w(input logic [3:0] a, input logic [7:0] v);
      clk(1);
      sw_wr_i <= 1;
      sw_addr_i <= a;
      sw_wdata_i <= v;
      clk(1);
      sw_wr_i <= 0;
   endtask
   task automatic sw_r(input logic [3:0] a, input logic [7:0] exp);
      clk(1);
      sw_rd_i <= 1;
      sw_addr_i <= a;
      clk(1);
      sw_rd_i <= 0;
      #1 cmp(sw_rdata_o, exp);
   endtask
   task automatic t_acc();
      sw_w(mab_pkg::OFS_ACC, 8'h8F);
      ex(mab_pkg::MAB_ADD_IMM_TO_ACC, 8'h71, 7'h00, 3'h0, 1'h0);
      settle();
      cmp(acc_o, 8'h00);
      sw_r(mab_pkg::OFS_STATUS, 8'h07);
      sw_w(mab_pkg::OFS_ACC, 8'hF0);
      ex(mab_pkg::MAB_AND_IMM_TO_ACC, 8'h3C, 7'h00, 3'h0, 1'h0);
      settle();
      cmp(acc_o, 8'h30);
      cmp({5'h00, status_o}, 8'h03);
      sw_r(4'hF, 8'h00);
      sw_r(mab_pkg::OFS_EXEC, 8'h00);
   endtask
   task automatic t_file();
      mem[127] = 8'h08;
      mem[32] = 8'h55;
      sw_w(mab_pkg::OFS_ACC, 8'h08);
      ex(mab_pkg::MAB_ADD_ACC_FILE, 8'h00, 7'h7F, 3'h0, mab_pkg::DEST_FILE);
      settle();
      cmp(mem[127], 8'h10);
      cmp16({acc_o[7:0], 5'h00, status_o}, {8'h08, 8'h02});
      ex(mab_pkg::MAB_ZERO_FILE_REG, 8'h00, 7'h20, 3'h0, 1'h0);
      settle();
      cmp16({mem[32][7:0], 5'h00, status_o}, 16'h0006);
      ex(mab_pkg::MAB_AND_ACC_FILE, 8'h00, 7'h7F, 3'h0, mab_pkg::DEST_ACC);
      settle();
      cmp16({acc_o, mem[127]}, 16'h0010);
   endtask
   task automatic t_bits();
      mem[6] = 8'h00;
      mem[48] = 8'hFF;
      ex(mab_pkg::MAB_BIT_SET_OP, 8'h00, mab_pkg::PORT_FADDR, 3'h1, 1'h0);
      ex(mab_pkg::MAB_BIT_CLEAR_OP, 8'h00, 7'h30, 3'h7, 1'h0);
      settle();
      cmp(mem[6], 8'hA7);
      cmp(mem[48], 8'h7F);
      cmp({5'h00, status_o}, 8'h06);
   endtask
   // each row: skip kind, bit tested, expected accumulator after the add
   task automatic t_skip();
      mem[64] = 8'h04;
      for (int i = 0; i < 4; i++) begin
         sw_w(mab_pkg::OFS_ACC, 8'h10);
         ex(i[0] ? mab_pkg::MAB_SKIP_IF_BIT_ZERO : mab_pkg::MAB_SKIP_IF_BIT_ONE, 8'h00, 7'h40,
            i[1] ? 3'h0 : 3'h2, 1'h0);
         ex(mab_pkg::MAB_ADD_IMM_TO_ACC, 8'h01, 7'h00, 3'h0, 1'h0);
         #1 cmp({7'h00, nop_cycle_o}, {7'h00, !(i[0] ^ i[1])});
         settle();
         cmp(acc_o, 8'h10 + 8'(i[0] ^ i[1]));
      end
   endtask
   task automatic report_and_stop();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      clk(16);
      resetn_i <= 1;
      clk(4);
      t_acc();
      t_file();
      t_bits();
      t_skip();
      report_and_stop();
   end
endmodule
